// ===== adcsq_control.sv
// Dual-unit converter sequencer control with an AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_consts.svh"

module adcsq_control
	import adcsq_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             standby,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic [1:0]            convReq,
	output logic [1:0][2:0]       convChan,
	output logic [1:0]            convTick,
	input  wire logic [1:0]       convDone,
	input  wire logic [1:0][9:0]  convResult,
	input  wire logic [1:0]       extTrig,
	output logic [1:0]            convEndIrq,
	output logic [1:0]            dmaReq
);

	adcsq_state_s stateReg;
	adcsq_state_s stateNext;
	logic         wrFire;
	logic         rdFire;
	logic         dualWrite;

	// ==========================================================================
	// Register images
	// ==========================================================================
	function automatic logic [15:0] csrWord(input adcsq_unit_s u);
		logic [15:0] w;
		w = 16'h0000;
		w[`ADCSQ_BIT_FLAG] = u.flag;
		w[`ADCSQ_BIT_IE] = u.ie;
		w[`ADCSQ_BIT_GO] = u.go;
		w[`ADCSQ_BIT_DSEL] = u.dsel;
		w[`ADCSQ_BIT_EXT_TRIGGER_ENABLE] = u.ext_trigger_enable;
		w[`ADCSQ_LSB_CKS +: 2] = u.cks;
		w[`ADCSQ_LSB_MODE +: 2] = u.mode;
		w[`ADCSQ_LSB_CH +: 2] = u.ch;
		return w;
	endfunction : csrWord

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
		return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	function automatic logic isResult(input logic [7:0] a);
		return a >= `ADCSQ_OFS_RES_FIRST && a <= `ADCSQ_OFS_RES_LAST && a[1:0] == 2'h0;
	endfunction : isResult

	function automatic logic [2:0] resIndex(input logic [7:0] a);
		logic [7:0] d;
		d = 8'(a - `ADCSQ_OFS_RES_FIRST);
		return d[4:2];
	endfunction : resIndex

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		logic [15:0] v;
		logic [7:0]  csrOfs;
		logic        start;
		logic        last;
		stateNext = stateReg;
		v = 16'h0000;
		csrOfs = 8'h00;
		start = 1'b0;
		last = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			stateNext.awHave = 1'b1;
			stateNext.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			stateNext.wHave = 1'b1;
			stateNext.wData = s_axi_wdata[15:0];
			stateNext.wStrb = s_axi_wstrb[1:0];
		end
		if (stateReg.bvalid && s_axi_bready) begin
			stateNext.bvalid = 1'b0;
		end
		wrFire = stateReg.awHave && stateReg.wHave && !stateReg.bvalid;
		if (wrFire) begin
			stateNext.awHave = 1'b0;
			stateNext.wHave = 1'b0;
			stateNext.bvalid = 1'b1;
			stateNext.bresp = (stateReg.awAddr == `ADCSQ_OFS_CSR0 || stateReg.awAddr == `ADCSQ_OFS_CSR1 ||
				stateReg.awAddr == `ADCSQ_OFS_DUAL || isResult(stateReg.awAddr)) ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
		end
		dualWrite = wrFire && stateReg.awAddr == `ADCSQ_OFS_DUAL && stateReg.wStrb[0];
		if (dualWrite) begin
			stateNext.dual = stateReg.wData[`ADCSQ_BIT_DUAL_SAMPLE_GO];
		end
		if (stateReg.rvalid && s_axi_rready) begin
			stateNext.rvalid = 1'b0;
		end
		rdFire = s_axi_arvalid && s_axi_arready;
		if (rdFire) begin
			stateNext.rvalid = 1'b1;
			stateNext.rAddr = s_axi_araddr;
			stateNext.rresp = `ADCSQ_RESP_OKAY;
			if (s_axi_araddr == `ADCSQ_OFS_CSR0) begin
				stateNext.rdata = {16'h0000, csrWord(stateReg.u[0])};
			end else if (s_axi_araddr == `ADCSQ_OFS_CSR1) begin
				stateNext.rdata = {16'h0000, csrWord(stateReg.u[1])};
			end else if (s_axi_araddr == `ADCSQ_OFS_DUAL) begin
				stateNext.rdata = {31'h00000000, stateReg.dual};
			end else if (isResult(s_axi_araddr)) begin
				stateNext.rdata = {22'h000000, stateReg.res[resIndex(s_axi_araddr)]};
			end else begin
				stateNext.rdata = 32'h00000000;
				stateNext.rresp = `ADCSQ_RESP_SLVERR;
			end
		end
		for (int i = 0; i < 2; i++) begin
			csrOfs = (i == 0) ? `ADCSQ_OFS_CSR0 : `ADCSQ_OFS_CSR1;
			start = 1'b0;
			stateNext.u[i].dma = 1'b0;
			if (stateReg.u[i].div == ((stateReg.u[i].cks == `ADCSQ_CKS_DIV4) ? `ADCSQ_TERM_DIV4 :
				(stateReg.u[i].cks == `ADCSQ_CKS_DIV8) ? `ADCSQ_TERM_DIV8 : `ADCSQ_TERM_DIV16)) begin
				stateNext.u[i].div = 4'h0;
				stateNext.u[i].tick = 1'b1;
			end else begin
				stateNext.u[i].div = 4'(stateReg.u[i].div + 4'h1);
				stateNext.u[i].tick = 1'b0;
			end
			if (rdFire && s_axi_araddr == csrOfs && stateReg.u[i].flag) begin
				stateNext.u[i].armed = 1'b1;
			end
			// A read of one of this unit's own results while the DMA route is chosen acknowledges its flag.
			if (rdFire && isResult(s_axi_araddr) && resIndex(s_axi_araddr) == 3'(i * 4) + 3'(s_axi_araddr[3:2])
				&& stateReg.u[i].dsel && resIndex(s_axi_araddr) >> 2 == 3'(i)) begin
				stateNext.u[i].flag = 1'b0;
			end
			if (wrFire && stateReg.awAddr == csrOfs) begin
				v = merge(csrWord(stateReg.u[i]), stateReg.wData, stateReg.wStrb);
				if (!v[`ADCSQ_BIT_FLAG] && stateReg.u[i].armed) begin
					stateNext.u[i].flag = 1'b0;
				end
				stateNext.u[i].armed = 1'b0;
				stateNext.u[i].ie = v[`ADCSQ_BIT_IE];
				stateNext.u[i].dsel = v[`ADCSQ_BIT_DSEL];
				stateNext.u[i].ext_trigger_enable = v[`ADCSQ_BIT_EXT_TRIGGER_ENABLE];
				if (v[`ADCSQ_LSB_CKS +: 2] != `ADCSQ_CKS_RSVD) begin
					stateNext.u[i].cks = v[`ADCSQ_LSB_CKS +: 2];
				end
				if (v[`ADCSQ_LSB_MODE +: 2] != ADCSQ_RSVD) begin
					stateNext.u[i].mode = adcsq_mode_e'(v[`ADCSQ_LSB_MODE +: 2]);
				end
				stateNext.u[i].ch = v[`ADCSQ_LSB_CH +: 2];
				if (v[`ADCSQ_BIT_GO] && !stateReg.u[i].go) begin
					start = 1'b1;
				end else if (!v[`ADCSQ_BIT_GO]) begin
					stateNext.u[i].go = 1'b0;
					stateNext.u[i].seq = ADCSQ_IDLE;
					stateNext.u[i].req = 1'b0;
				end
			end
			if (dualWrite && stateReg.wData[`ADCSQ_BIT_DUAL_SAMPLE_GO] && !stateReg.u[i].go) begin
				start = 1'b1;
			end
			if (extTrig[i] && stateReg.u[i].ext_trigger_enable && !stateReg.u[i].go) begin
				start = 1'b1;
			end
			if (start) begin
				// Settings written in the same beat are already in stateNext.
				stateNext.u[i].go = 1'b1;
				stateNext.u[i].seq = ADCSQ_CONV;
				stateNext.u[i].req = 1'b1;
				stateNext.u[i].cur = (stateNext.u[i].mode == ADCSQ_SINGLE) ? stateNext.u[i].ch : 2'h0;
			end
			if (stateReg.u[i].seq == ADCSQ_CONV && convDone[i] && stateNext.u[i].go && !start) begin
				stateNext.res[3'(i * 4) + 3'(stateReg.u[i].cur)] = convResult[i];
				last = stateReg.u[i].mode == ADCSQ_SINGLE || stateReg.u[i].cur == stateReg.u[i].ch;
				if (last) begin
					stateNext.u[i].flag = 1'b1;
					stateNext.u[i].dma = stateReg.u[i].dsel;
					if (stateReg.u[i].mode != ADCSQ_SCAN) begin
						stateNext.u[i].go = 1'b0;
						stateNext.u[i].seq = ADCSQ_IDLE;
						stateNext.u[i].req = 1'b0;
					end else begin
						stateNext.u[i].cur = 2'h0;
					end
				end else begin
					stateNext.u[i].cur = 2'(stateReg.u[i].cur + 2'h1);
				end
			end
		end
		if (stateReg.dual && !stateReg.u[0].go && !stateReg.u[1].go && !dualWrite) begin
			stateNext.dual = 1'b0;
		end
		if (!rst_n || standby) begin
			stateNext = '0;
			stateNext.dual = 1'(`ADCSQ_DUAL_RESET >> `ADCSQ_BIT_DUAL_SAMPLE_GO);
			for (int i = 0; i < 2; i++) begin
				stateNext.u[i].cks = 2'(`ADCSQ_CSR_RESET >> `ADCSQ_LSB_CKS);
			end
		end
	end

	always_ff @(posedge clock) begin
		stateReg <= stateNext;
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign s_axi_awready = !stateReg.awHave && !stateReg.bvalid;
	assign s_axi_wready = !stateReg.wHave && !stateReg.bvalid;
	assign s_axi_bvalid = stateReg.bvalid;
	assign s_axi_bresp = stateReg.bresp;
	assign s_axi_arready = !stateReg.rvalid;
	assign s_axi_rvalid = stateReg.rvalid;
	assign s_axi_rdata = stateReg.rdata;
	assign s_axi_rresp = stateReg.rresp;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			convReq[i] = stateReg.u[i].req;
			convChan[i] = {1'(i), stateReg.u[i].cur};
			convTick[i] = stateReg.u[i].tick;
			convEndIrq[i] = stateReg.u[i].flag && stateReg.u[i].ie && !stateReg.u[i].dsel;
			dmaReq[i] = stateReg.u[i].dma;
		end
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_done0;
		stateReg.u[0].seq == ADCSQ_CONV && convDone[0] && stateReg.u[0].mode == ADCSQ_SINGLE && !wrFire;
	endsequence

	sequence s_idle0;
		!stateReg.u[0].go && stateReg.u[0].flag && stateReg.u[0].seq == ADCSQ_IDLE;
	endsequence

	a_reserved_zero: assert property ((stateReg.rvalid && stateReg.rAddr == `ADCSQ_OFS_CSR0) |->
		stateReg.rdata[10:8] == 3'h0 && stateReg.rdata[3:2] == 2'h0 && stateReg.rdata[31:16] == 16'h0000)
		else $error("reserved control bits read nonzero");
	a_tick_div4: assert property ((convTick[0] && stateReg.u[0].cks == `ADCSQ_CKS_DIV4) ##1
		(stateReg.u[0].cks == `ADCSQ_CKS_DIV4 && !convTick[0]) [*3] |=> convTick[0])
		else $error("divide-by-four tick spacing wrong");
	a_mode_legal: assert property (stateReg.u[0].mode != ADCSQ_RSVD)
		else $error("reserved mode stored");
	a_single_chan: assert property ((convReq[0] && stateReg.u[0].mode == ADCSQ_SINGLE) |->
		convChan[0] == {1'b0, stateReg.u[0].ch})
		else $error("single mode converts wrong channel");
	a_flag_cause: assert property ($rose(stateReg.u[0].flag) |-> $past(convDone[0]))
		else $error("end flag set without completion");
	a_dual_holds: assert property ((stateReg.dual && (stateReg.u[0].go || stateReg.u[1].go) && !wrFire
		&& !standby) |=> stateReg.dual)
		else $error("dual bit dropped during conversion");
	a_dual_clears: assert property ((stateReg.dual && !stateReg.u[0].go && !stateReg.u[1].go && !wrFire
		&& !standby) |=> !stateReg.dual)
		else $error("dual bit not cleared after both units");
	a_single_end: assert property (s_done0 ##0 !standby |=> s_idle0)
		else $error("single conversion did not finish cleanly");
	a_irq_gate: assert property (convEndIrq[0] |->
		stateReg.u[0].flag && stateReg.u[0].ie && !stateReg.u[0].dsel)
		else $error("interrupt without its conditions");
	a_dma_route: assert property (dmaReq[0] |-> stateReg.u[0].flag && !convEndIrq[0])
		else $error("dma request without flag or with interrupt");
	a_reset_csr: assert property (standby |=>
		stateReg.u[0].cks == 2'h1 && !stateReg.u[0].go && !stateReg.dual)
		else $error("standby did not reset registers");

endmodule : adcsq_control

`default_nettype wire

// ===== adcsq_consts.svh
// Register offsets, field positions, reset values and divider counts of the converter control block.
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

`define ADCSQ_OFS_CSR0      8'h00
`define ADCSQ_OFS_CSR1      8'h04
`define ADCSQ_OFS_DUAL      8'h08
`define ADCSQ_OFS_RES_FIRST 8'h10
`define ADCSQ_OFS_RES_LAST  8'h2C

`define ADCSQ_BIT_FLAG  15
`define ADCSQ_BIT_IE    14
`define ADCSQ_BIT_GO    13
`define ADCSQ_BIT_DSEL  12
`define ADCSQ_BIT_EXT_TRIGGER_ENABLE  11
`define ADCSQ_LSB_CKS   6
`define ADCSQ_LSB_MODE  4
`define ADCSQ_LSB_CH    0
`define ADCSQ_BIT_DUAL_SAMPLE_GO  0

`define ADCSQ_CSR_RESET  16'h0040
`define ADCSQ_DUAL_RESET 16'h0000

`define ADCSQ_CKS_DIV4   2'h0
`define ADCSQ_CKS_DIV8   2'h1
`define ADCSQ_CKS_DIV16  2'h2
`define ADCSQ_CKS_RSVD   2'h3
`define ADCSQ_TERM_DIV4  4'h3
`define ADCSQ_TERM_DIV8  4'h7
`define ADCSQ_TERM_DIV16 4'hF

`define ADCSQ_RESP_OKAY   2'h0
`define ADCSQ_RESP_SLVERR 2'h2

`endif

// ===== adcsq_pkg.sv
// Types shared by the converter control block.
`default_nettype none

package adcsq_pkg;

	typedef enum logic [1:0] {
		ADCSQ_SINGLE = 2'h0,
		ADCSQ_RSVD   = 2'h1,
		ADCSQ_MULTI  = 2'h2,
		ADCSQ_SCAN   = 2'h3
	} adcsq_mode_e;

	typedef enum logic {
		ADCSQ_IDLE = 1'b0,
		ADCSQ_CONV = 1'b1
	} adcsq_seq_e;

	typedef struct packed {
		adcsq_seq_e  seq;
		logic        flag;
		logic        ie;
		logic        go;
		logic        dsel;
		logic        ext_trigger_enable;
		logic        armed;
		logic        req;
		logic        dma;
		logic        tick;
		logic [1:0]  cks;
		adcsq_mode_e mode;
		logic [1:0]  ch;
		logic [1:0]  cur;
		logic [3:0]  div;
	} adcsq_unit_s;

	typedef struct packed {
		adcsq_unit_s [1:0] u;
		logic              dual;
		logic [7:0][9:0]   res;
		logic              awHave;
		logic              wHave;
		logic [7:0]        awAddr;
		logic [15:0]       wData;
		logic [1:0]        wStrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [7:0]        rAddr;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} adcsq_state_s;

endpackage : adcsq_pkg

`default_nettype wire

// ===== adcsq_core_model.sv
// Behavioural model of the analog sample-and-hold and approximation core.
`timescale 1ns/100ps
`default_nettype none

module adcsq_core_model (
	input  wire logic            clock,
	input  wire logic [1:0]      convReq,
	input  wire logic [1:0][2:0] convChan,
	input  wire logic [1:0]      convTick,
	input  wire logic [3:0]      lat,
	output logic [1:0]           convDone,
	output logic [1:0][9:0]      convResult
);
	logic [1:0][3:0] cnt;
	logic [9:0]      pat;

	initial begin
		cnt = '0;
		pat = '0;
		convDone = '0;
		convResult = '0;
	end

	// Between strobes the result lines change every cycle, so stale data never passes for a result.
	always @(posedge clock) begin
		pat <= pat + 10'h3A7;
		for (int i = 0; i < 2; i++) begin
			convDone[i] <= 1'b0;
			convResult[i] <= pat;
			if (convReq[i] !== 1'b1) begin
				cnt[i] <= 4'h0;
			end else if (convTick[i] && cnt[i] == lat) begin
				cnt[i] <= 4'h0;
				convDone[i] <= 1'b1;
				convResult[i] <= {7'h50, convChan[i]};
			end else if (convTick[i]) begin
				cnt[i] <= cnt[i] + 4'h1;
			end
		end
	end
endmodule : adcsq_core_model

`default_nettype wire

// ===== adc_sequencer_control_bench.sv
// Self-checking bench of the converter sequencer control.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_consts.svh"

module adc_sequencer_control_bench;
	localparam logic [7:0] C0 = `ADCSQ_OFS_CSR0;
	localparam logic [7:0] C1 = `ADCSQ_OFS_CSR1;
	localparam logic [7:0] DU = `ADCSQ_OFS_DUAL;
	localparam logic [1:0] OK = `ADCSQ_RESP_OKAY;
	localparam logic [1:0] SE = `ADCSQ_RESP_SLVERR;
	logic            clock, rst_n, standby, awValid, awReady, wValid, wReady, bValid, bReady;
	logic            arValid, arReady, rValid, rReady;
	logic [7:0]      awAddr, arAddr;
	logic [31:0]     wData, rData, rnd;
	logic [1:0]      bResp, rResp, convReq, convTick, convDone, extTrig, convEndIrq, dmaReq, ch;
	logic [1:0][2:0] convChan;
	logic [1:0][9:0] convResult;
	logic [3:0]      lat;
	logic [15:0]     lo, v;
	logic [33:0]     rx;
	logic [33:0]     rq[$];
	logic [1:0]      bq[$];
	int              errors, samples_checked, dmaCount;

	adcsq_control dut (.clock(clock), .rst_n(rst_n), .standby(standby), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.convReq(convReq), .convChan(convChan), .convTick(convTick), .convDone(convDone),
		.convResult(convResult), .extTrig(extTrig), .convEndIrq(convEndIrq), .dmaReq(dmaReq));
	adcsq_core_model core (.clock(clock), .convReq(convReq), .convChan(convChan), .convTick(convTick),
		.lat(lat), .convDone(convDone), .convResult(convResult));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic finish_test();
		$display("Checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic bail();
		errors++;
		finish_test();
	endtask : bail

	// Ready and valid only move at rising edges, so the value seen at the falling edge is the one sampled next.
	task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		logic ta, tw, tb;
		int   n;
		n = 0;
		tb = 1'b0;
		bq.push_back(r);
		@(posedge clock);
		awAddr <= a;
		wData <= {16'h0000, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!tb) begin
			@(negedge clock);
			ta = awValid && awReady;
			tw = wValid && wReady;
			tb = bValid;
			if (++n > 200) bail();
			@(posedge clock);
			if (ta) awValid <= 1'b0;
			if (tw) wValid <= 1'b0;
			if (tb) bReady <= 1'b0;
		end
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		logic ta, tr;
		int   n;
		n = 0;
		tr = 1'b0;
		rq.push_back({r, e});
		@(posedge clock);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		while (!tr) begin
			@(negedge clock);
			ta = arValid && arReady;
			tr = rValid;
			if (++n > 200) bail();
			@(posedge clock);
			if (ta) arValid <= 1'b0;
			if (tr) rReady <= 1'b0;
		end
	endtask : axr

	task automatic wreq(input int u, input logic l);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			if (++n > 3000) bail();
		end while (convReq[u] !== l);
		@(posedge clock);
	endtask : wreq

	task automatic wdone(input int k);
		int n;
		n = 0;
		while (k > 0) begin
			@(negedge clock);
			if (convDone[0] === 1'b1) k--;
			if (++n > 3000) bail();
		end
		@(posedge clock);
	endtask : wdone

	task automatic tper(input logic [31:0] e);
		int n;
		for (int j = 0; j < 2; j++) begin
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (convTick[0] !== 1'b1 && n < 40);
		end
		chk("tick period", 32'(n), e);
	endtask : tper

	// ============================================================
	// Monitor
	always @(posedge clock) begin
		if (bValid && bReady) chk("bresp", 32'(bq.pop_front()), 32'(bResp));
		if (rValid && rReady) begin
			rx = rq.pop_front();
			chk("rdata", rx[31:0], rData);
			chk("rresp", 32'(rx[33:32]), 32'(rResp));
		end
		if (dmaReq[1] === 1'b1) dmaCount++;
	end

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ============================================================
	// Scenarios
	initial begin
		{rst_n, standby, awValid, wValid, bReady, arValid, rReady, extTrig, awAddr, arAddr, wData} = '0;
		{errors, samples_checked, dmaCount} = '0;
		lat = 4'h4;
		rnd = 32'hCACA;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		axr(C0, 32'h0040, OK);
		axr(C1, 32'h0040, OK);
		axr(DU, 32'h0000, OK);
		axr(8'h30, 32'h0000, SE);
		axw(8'h30, 16'hFFFF, SE);
		axw(C0, 16'h07DC, OK);
		axr(C0, 32'h0040, OK);
		axw(DU, 16'hFFFE, OK);
		axr(DU, 32'h0000, OK);
		for (int c = 0; c < 3; c++) begin
			rnd = lfsr(rnd);
			ch = rnd[1:0];
			lat <= 4'h4 + {1'b0, rnd[4:2]};
			lo = {8'h00, 2'(c), 4'h0, ch};
			v = lo | 16'h6000;
			axw(C0, v, OK);
			@(negedge clock);
			chk("request", 32'(convReq[0]), 32'h1);
			chk("channel", 32'(convChan[0]), 32'(ch));
			tper(32'(4 << c));
			axr(C0, 32'(v), OK);
			wreq(0, 1'b0);
			@(negedge clock);
			chk("irq", 32'(convEndIrq[0]), 32'h1);
			axr(C0, 32'(v ^ 16'hA000), OK);
			axr(8'h10 + {4'h0, ch, 2'b00}, {22'h0, 7'h50, 1'b0, ch}, OK);
			axw(C0, lo | 16'h8000, OK);
			axw(C0, lo, OK);
			axr(C0, 32'(lo | 16'h8000), OK);
			axw(C0, lo, OK);
			axr(C0, 32'(lo), OK);
		end
		axw(C1, 16'h7022, OK);
		wreq(1, 1'b0);
		@(negedge clock);
		chk("dma pulses", 32'(dmaCount), 32'h1);
		chk("irq masked", 32'(convEndIrq[1]), 32'h0);
		axr(C1, 32'hD022, OK);
		for (int k = 4; k < 7; k++) axr(8'h10 + 8'(4 * k), 32'h0280 + 32'(k), OK);
		axr(`ADCSQ_OFS_RES_LAST, 32'h0000, OK);
		axr(C1, 32'h5022, OK);
		axw(C0, 16'h0031, OK);
		extTrig <= 2'b01;
		@(posedge clock);
		extTrig <= 2'b00;
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk("trigger off", 32'(convReq[0]), 32'h0);
		axw(C0, 16'h0831, OK);
		extTrig <= 2'b01;
		@(posedge clock);
		extTrig <= 2'b00;
		wreq(0, 1'b1);
		wdone(3);
		axr(C0, 32'hA831, OK);
		axw(C0, 16'h0031, OK);
		wreq(0, 1'b0);
		lat <= 4'h8;
		axw(C0, 16'h0003, OK);
		axw(C1, 16'h0000, OK);
		axw(DU, 16'h0001, OK);
		axr(DU, 32'h0001, OK);
		wreq(0, 1'b0);
		wreq(1, 1'b0);
		axr(DU, 32'h0000, OK);
		axr(8'h1C, 32'h0283, OK);
		axr(8'h20, 32'h0284, OK);
		axw(C0, 16'h4083, OK);
		axw(DU, 16'h0001, OK);
		standby <= 1'b1;
		@(posedge clock);
		standby <= 1'b0;
		axr(C0, 32'h0040, OK);
		axr(DU, 32'h0000, OK);
		chk("standby idle", 32'(convReq), 32'h0);
		finish_test();
	end
endmodule : adc_sequencer_control_bench

`default_nettype wire
